//--- wszc_waveform_zero_cross.v
`timescale 1ns/1ns
`include "wszc_consts.vh"

module wszc_waveform_zero_cross
(
   input  wire        i_clk,           // master clock
   input  wire        i_resetn,        // synchronous reset, active low
   input  wire        i_cur_bit,       // current modulator bitstream pin
   input  wire        i_volt_bit,      // voltage modulator bitstream pin
   input  wire        i_battery_mode,  // low power battery mode
   input  wire        i_sleep_mode,    // low power sleep mode
   input  wire [11:0] i_awaddr,        // axi write address
   input  wire        i_awvalid,       // axi write address valid
   output reg         o_awready,       // axi write address ready
   input  wire [31:0] i_wdata,         // axi write data
   input  wire [3:0]  i_wstrb,         // axi write strobes
   input  wire        i_wvalid,        // axi write data valid
   output reg         o_wready,        // axi write data ready
   output reg  [1:0]  o_bresp,         // axi write response
   output reg         o_bvalid,        // axi write response valid
   input  wire        i_bready,        // axi write response ready
   input  wire [11:0] i_araddr,        // axi read address
   input  wire        i_arvalid,       // axi read address valid
   output reg         o_arready,       // axi read address ready
   output reg  [31:0] o_rdata,         // axi read data
   output reg  [1:0]  o_rresp,         // axi read response
   output reg         o_rvalid,        // axi read data valid
   input  wire        i_rready,        // axi read data ready
   output reg  [2:0]  o_current_amp_gain, // current amplifier gain code
   output reg  [2:0]  o_volt_amp_gain,    // voltage amplifier gain code
   output reg         o_mod_sample_en,    // modulator sample enable pulse
   output reg         o_adc_powerdown,    // converters powered down
   output reg  [23:0] o_cur_sample,       // current word to energy path
   output reg  [23:0] o_volt_sample,      // voltage word to energy path
   output reg         o_sample_valid,     // full-rate sample strobe
   output reg         o_irq               // pending metering interrupt
);

   // synchronisers for pins
   reg        cur_s1;
   reg        cur_s2;
   reg        volt_s1;
   reg        volt_s2;
   reg        bat_s1;
   reg        bat_s2;
   reg        slp_s1;
   reg        slp_s2;

   // configuration and status
   reg  [7:0]  pga_gain_select;
   reg  [1:0]  sample_rate_field;
   reg         lpf_bypass;
   reg         new_sample_flag;
   reg         zero_cross_flag;
   reg  [7:0]  irq_enable_three;
   reg  [23:0] wave_one;
   reg  [15:0] wave_two;

   // converter state
   reg  [2:0]  div_cnt;
   reg  [5:0]  bit_cnt;
   reg  [5:0]  cur_ones;
   reg  [5:0]  volt_ones;
   reg  [2:0]  rate_cnt;
   reg  [23:0] lpf_state;
   reg         zx_sign;
   reg         zx_primed;

   wire        powerdown = bat_s2 | slp_s2;
   wire        frame_end = o_mod_sample_en && (bit_cnt == `WSZC_BITS_PER_SAMP - 6'd1);

   // signed average of the bitstream, scaled so 32 ones reach saturation
   function [23:0] wszc_decimate;
      input [5:0] ones;
      reg   [6:0] diff;
      reg   [23:0] word;
      begin
         diff = {ones, 1'b0} - 7'd32;
         word = {diff, 17'h0000};
         // clamp positive words at the converter ceiling
         if (!word[23] && word > `WSZC_SAT_MAG)
            word = `WSZC_SAT_MAG;                            // [RQ7]
         wszc_decimate = word;
      end
   endfunction

   // decimated words including the counts of this last bit
   wire [5:0]  cur_ones_n  = cur_ones + {5'h00, cur_s2};
   wire [5:0]  volt_ones_n = volt_ones + {5'h00, volt_s2};
   wire [23:0] cur_word    = wszc_decimate(cur_ones_n);     // [RQ6] [RQ8]
   wire [23:0] volt_word   = wszc_decimate(volt_ones_n);    // [RQ6]

   // single-pole filter, step 1/64 at 25.6 kHz gives a 63.7 Hz pole
   wire [24:0] lpf_err  = {volt_word[23], volt_word} - {lpf_state[23], lpf_state};
   wire [24:0] lpf_step = $signed(lpf_err) >>> `WSZC_LPF_SHIFT;
   wire [23:0] lpf_next = lpf_state + lpf_step[23:0];       // [RQ17]
   wire [23:0] zx_src   = lpf_bypass ? volt_word : lpf_next; // [RQ16]
   wire        zx_event = frame_end && !powerdown && zx_primed && (zx_src[23] != zx_sign);

   // decimation by 1,2,4,8 of the full-rate stream
   wire [2:0]  rate_top = (3'd1 << sample_rate_field) - 3'd1; // [RQ12] [RQ23]
   wire        wave_event = frame_end && !powerdown && (rate_cnt == rate_top);

   // two flops on the bitstream and mode pins before use
   always @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         cur_s1  <= 1'b0;
         cur_s2  <= 1'b0;
         volt_s1 <= 1'b0;
         volt_s2 <= 1'b0;
         bat_s1  <= 1'b0;
         bat_s2  <= 1'b0;
         slp_s1  <= 1'b0;
         slp_s2  <= 1'b0;
      end
      else
      begin
         cur_s1  <= i_cur_bit;
         cur_s2  <= cur_s1;
         volt_s1 <= i_volt_bit;
         volt_s2 <= volt_s1;
         bat_s1  <= i_battery_mode;
         bat_s2  <= bat_s1;
         slp_s1  <= i_sleep_mode;
         slp_s2  <= slp_s1;
      end
   end

   // modulator clock divider and bit averaging; held cleared while powered down
   always @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         div_cnt         <= 3'd0;
         o_mod_sample_en <= 1'b0;
         o_adc_powerdown <= 1'b0;
         bit_cnt         <= 6'd0;
         cur_ones        <= 6'd0;
         volt_ones       <= 6'd0;
      end
      else
      begin
         o_adc_powerdown <= powerdown;                       // [RQ4]
         if (powerdown)
         begin
            div_cnt         <= 3'd0;                         // [RQ4]
            o_mod_sample_en <= 1'b0;
            bit_cnt         <= 6'd0;
            cur_ones        <= 6'd0;
            volt_ones       <= 6'd0;
         end
         else
         begin
            div_cnt         <= (div_cnt == `WSZC_MOD_DIV - 3'd1) ? 3'd0 : div_cnt + 3'd1;
            o_mod_sample_en <= (div_cnt == `WSZC_MOD_DIV - 3'd1); // [RQ5]
            if (o_mod_sample_en)
            begin
               if (frame_end)
               begin
                  bit_cnt   <= 6'd0;
                  cur_ones  <= 6'd0;
                  volt_ones <= 6'd0;
               end
               else
               begin
                  bit_cnt   <= bit_cnt + 6'd1;
                  cur_ones  <= cur_ones_n;
                  volt_ones <= volt_ones_n;
               end
            end
         end
      end
   end

   // full-rate words to the energy path, filter and zero cross tracking
   always @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_cur_sample   <= 24'h000000;
         o_volt_sample  <= 24'h000000;
         o_sample_valid <= 1'b0;
         lpf_state      <= 24'h000000;
         zx_sign        <= 1'b0;
         zx_primed      <= 1'b0;
         rate_cnt       <= 3'd0;
      end
      else
      begin
         // energy path never waits on the waveform side
         o_sample_valid <= frame_end && !powerdown;         // [RQ11]
         if (frame_end && !powerdown)
         begin
            o_cur_sample  <= cur_word;                       // [RQ3] [RQ9]
            o_volt_sample <= volt_word;                      // [RQ3]
            lpf_state     <= lpf_next;
            zx_sign       <= zx_src[23];
            zx_primed     <= 1'b1;
            rate_cnt      <= (rate_cnt >= rate_top) ? 3'd0 : rate_cnt + 3'd1;
         end
      end
   end

   // axi handshake decode
   wire        wr_go    = i_awvalid && i_wvalid && !o_bvalid && !o_awready;
   wire [9:0]  wr_idx   = i_awaddr[11:2];
   wire        rd_go    = i_arvalid && !o_rvalid && !o_arready;
   wire [9:0]  rd_idx   = i_araddr[11:2];
   wire        rd_wave  = rd_go && (rd_idx == `WSZC_IDX_WAVE_ONE || rd_idx == `WSZC_IDX_WAVE_TWO);
   wire        wr_st3   = wr_go && wr_idx == `WSZC_IDX_IRQ_ST3 && i_wstrb[0];
   wire [2:0]  g_cur    = i_wdata[`WSZC_GAIN_CUR_LSB +: 3];
   wire [2:0]  g_volt   = i_wdata[`WSZC_GAIN_VOLT_LSB +: 3];

   // register writes; reserved gain codes leave that field unchanged
   always @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         pga_gain_select   <= `WSZC_RST_GAIN;
         // rate and bypass share one reset word, so both come from it
         {lpf_bypass, sample_rate_field} <= `WSZC_RST_WAVEFORM_MODE_REG;
         irq_enable_three  <= `WSZC_RST_IRQ_EN3;
         o_awready         <= 1'b0;
         o_wready          <= 1'b0;
         o_bvalid          <= 1'b0;
         o_bresp           <= `WSZC_RESP_OKAY;
      end
      else
      begin
         o_awready <= wr_go;
         o_wready  <= wr_go;
         if (o_bvalid && i_bready)
            o_bvalid <= 1'b0;
         if (wr_go)
         begin
            o_bvalid <= 1'b1;
            o_bresp  <= `WSZC_RESP_OKAY;
            case (wr_idx)
               `WSZC_IDX_GAIN:
               begin
                  if (i_wstrb[0] && g_cur <= 3'd4)
                     pga_gain_select[2:0] <= g_cur;          // [RQ1] [RQ2]
                  if (i_wstrb[0] && g_volt <= 3'd4)
                     pga_gain_select[7:5] <= g_volt;         // [RQ1] [RQ2]
               end
               `WSZC_IDX_WAVEFORM_MODE_REG:
               begin
                  if (i_wstrb[0])
                  begin
                     sample_rate_field <= i_wdata[`WSZC_WM_RATE_LSB +: 2]; // [RQ12]
                     lpf_bypass        <= i_wdata[`WSZC_WM_LPF_OFF];       // [RQ16]
                  end
               end
               `WSZC_IDX_IRQ_EN3:
               begin
                  if (i_wstrb[0])
                     irq_enable_three <= {2'b00, i_wdata[5:0]};
               end
               `WSZC_IDX_IRQ_ST3,
               `WSZC_IDX_WAVE_ONE,
               `WSZC_IDX_WAVE_TWO:
                  o_bresp <= `WSZC_RESP_OKAY;
               default:
                  o_bresp <= `WSZC_RESP_SLVERR;
            endcase
         end
      end
   end

   // sticky flags, write one to clear; a new event wins over the clear
   always @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         new_sample_flag <= 1'b0;
         zero_cross_flag <= 1'b0;
      end
      else
      begin
         if (wave_event)
            new_sample_flag <= 1'b1;                         // [RQ15] [RQ21]
         else if (wr_st3 && i_wdata[`WSZC_BIT_NEWSAMP])
            new_sample_flag <= 1'b0;                         // [RQ15]
         if (zx_event)
            zero_cross_flag <= 1'b1;                         // [RQ19] [RQ22]
         else if (wr_st3 && i_wdata[`WSZC_BIT_ZX])
            zero_cross_flag <= 1'b0;                         // [RQ20]
      end
   end

   // decimated waveform samples and the read port
   reg  [23:0] wave_dec_cur;
   reg  [15:0] wave_dec_volt;

   always @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         wave_dec_cur  <= 24'h000000;
         wave_dec_volt <= 16'h0000;
         wave_one      <= 24'h000000;
         wave_two      <= 16'h0000;
      end
      else
      begin
         if (wave_event)
         begin
            wave_dec_cur  <= cur_word;                       // [RQ8]
            wave_dec_volt <= volt_word[23:8];                // [RQ10]
         end
         // either high word read captures both channels together
         if (rd_wave)
         begin
            wave_one <= wave_dec_cur;                        // [RQ14]
            wave_two <= wave_dec_volt;                       // [RQ14]
         end
      end
   end

   // read data; wave words return the freshly captured value
   reg  [31:0] next_rdata;
   reg  [1:0]  next_rresp;

   always @*
   begin
      next_rdata = 32'h00000000;
      next_rresp = `WSZC_RESP_OKAY;
      case (rd_idx)
         `WSZC_IDX_GAIN:     next_rdata = {24'h000000, pga_gain_select};
         `WSZC_IDX_WAVEFORM_MODE_REG:  next_rdata = {29'h0000000, lpf_bypass, sample_rate_field};
         `WSZC_IDX_IRQ_EN3:  next_rdata = {24'h000000, irq_enable_three};
         `WSZC_IDX_IRQ_ST3:  next_rdata = {26'h000000, new_sample_flag, 4'h0, zero_cross_flag};
         `WSZC_IDX_WAVE_ONE: next_rdata = {8'h00, wave_dec_cur};
         `WSZC_IDX_WAVE_TWO: next_rdata = {16'h0000, wave_dec_volt};
         default:            next_rresp = `WSZC_RESP_SLVERR;
      endcase
   end

   always @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h00000000;
         o_rresp   <= `WSZC_RESP_OKAY;
      end
      else
      begin
         o_arready <= rd_go;
         if (o_rvalid && i_rready)
            o_rvalid <= 1'b0;
         if (rd_go)
         begin
            o_rvalid <= 1'b1;
            o_rdata  <= next_rdata;
            o_rresp  <= next_rresp;
         end
      end
   end

   // gain pins and interrupt line, registered each cycle
   always @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_current_amp_gain <= 3'd0;
         o_volt_amp_gain    <= 3'd0;
         o_irq              <= 1'b0;
      end
      else
      begin
         o_current_amp_gain <= pga_gain_select[2:0];        // [RQ1]
         o_volt_amp_gain    <= pga_gain_select[7:5];        // [RQ1]
         o_irq <= (new_sample_flag & irq_enable_three[`WSZC_BIT_NEWSAMP]) // [RQ13] [RQ24]
                | (zero_cross_flag & irq_enable_three[`WSZC_BIT_ZX]);    // [RQ19] [RQ24]
      end
   end

endmodule

//--- wszc_consts.vh
// What this block does
// RQ1 - gain bits 2:0 current, 7:5 voltage
// RQ2 - five gains only: 1,2,4,8,16
// RQ3 - converter words feed waveform registers and energy path
// RQ4 - battery or sleep mode powers converters down
// RQ5 - modulator sample enable is clock divided by five
// RQ6 - decimator averages bitstream into 24-bit words
// RQ7 - same code both channels, saturate at 4194304
// RQ8 - current samples signed 24-bit, full rate clock/160
// RQ9 - current span about 0x28F5C2 to 0xD70A3E
// RQ10 - voltage span about 0x28F5 to 0xD70B
// RQ11 - waveform capture never disturbs energy path
// RQ12 - two-bit rate field picks output rate
// RQ13 - new sample plus enable raises interrupt
// RQ14 - high word read latches both samples
// RQ15 - new sample flag holds until cleared
// RQ16 - zero cross uses filter output unless bypassed
// RQ17 - filter single pole near 63.7 Hz
// RQ18 - software keeps filter on below 60 Hz
// RQ19 - zero cross sets flag, enable raises interrupt
// RQ20 - zero cross flag holds until cleared
// RQ21 - new sample flag and enable at bit 5
// RQ22 - zero cross flag and enable at bit 0
// RQ23 - rate codes 00..11 decimate by 1,2,4,8
// RQ24 - interrupt is OR of flag AND enable
`ifndef WSZC_CONSTS_VH
`define WSZC_CONSTS_VH
// register indices; byte address is four times the index
`define WSZC_IDX_GAIN       10'h000
`define WSZC_IDX_WAVEFORM_MODE_REG    10'h001
`define WSZC_IDX_IRQ_EN3    10'h0DB
`define WSZC_IDX_IRQ_ST3    10'h0DE
`define WSZC_IDX_WAVE_ONE   10'h0E2
`define WSZC_IDX_WAVE_TWO   10'h0E5
// field positions
`define WSZC_GAIN_CUR_LSB   0
`define WSZC_GAIN_VOLT_LSB  5
`define WSZC_WM_RATE_LSB    0
`define WSZC_WM_LPF_OFF     2
`define WSZC_BIT_ZX         0
`define WSZC_BIT_NEWSAMP    5
// reset values
`define WSZC_RST_GAIN       8'h00
`define WSZC_RST_WAVEFORM_MODE_REG    3'h0
`define WSZC_RST_IRQ_EN3    8'h00
// divider count, bits per sample, filter shift and saturation magnitude
`define WSZC_MOD_DIV        3'd5
`define WSZC_BITS_PER_SAMP  6'd32
`define WSZC_LPF_SHIFT      6
`define WSZC_SAT_MAG        24'h400000
// AXI responses
`define WSZC_RESP_OKAY      2'b00
`define WSZC_RESP_SLVERR    2'b10
`endif

//--- wszc_checker.sv
`timescale 1ns/1ns
module wszc_checker
(
   input wire        i_clk,              // clock
   input wire        i_resetn,           // reset
   input wire        i_battery_mode,     // battery
   input wire        i_sleep_mode,       // sleep
   input wire        i_bready,           // b ready
   input wire        o_bvalid,           // b valid
   input wire [1:0]  o_bresp,            // b resp
   input wire [2:0]  o_current_amp_gain, // cur gain
   input wire [2:0]  o_volt_amp_gain,    // volt gain
   input wire        o_mod_sample_en,    // mod enable
   input wire        o_adc_powerdown,    // power down
   input wire [23:0] o_cur_sample,       // cur word
   input wire [23:0] o_volt_sample,      // volt word
   input wire        o_sample_valid      // strobe
);
   reg [7:0] gap; // cycles since strobe
   reg       run; // gap may be judged
   // a power-down stops the stream mid-gap, so timing restarts after it
   always @(posedge i_clk)
   begin
      if (!i_resetn || o_adc_powerdown)
      begin
         gap <= 8'h00;
         run <= 1'b0;
      end
      else if (o_sample_valid)
      begin
         gap <= 8'h00;
         run <= 1'b1;
      end
      else
         gap <= gap + 8'h01;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   property p_mod;
      o_mod_sample_en |=> !o_mod_sample_en [*4] ##1 (o_mod_sample_en || o_adc_powerdown);
   endproperty
   a_mod: assert property (p_mod) else $error("mod enable spacing");
   property p_rate;
      o_sample_valid && run |-> gap == 8'd159;
   endproperty
   a_rate: assert property (p_rate) else $error("strobe spacing");
   property p_pd;
      o_adc_powerdown [*4] |-> !o_sample_valid;
   endproperty
   a_pd: assert property (p_pd) else $error("strobe while down");
   property p_pd_in;
      (i_battery_mode || i_sleep_mode) [*5] |-> o_adc_powerdown;
   endproperty
   a_pd_in: assert property (p_pd_in) else $error("no power down");
   property p_gain;
      o_current_amp_gain <= 3'h4 && o_volt_amp_gain <= 3'h4;
   endproperty
   a_gain: assert property (p_gain) else $error("gain code range");
   property p_sat;
      (o_cur_sample[23] ? o_cur_sample >= 24'hC00000 : o_cur_sample <= 24'h400000)
      && (o_volt_sample[23] ? o_volt_sample >= 24'hC00000 : o_volt_sample <= 24'h400000);
   endproperty
   a_sat: assert property (p_sat) else $error("word beyond limit");
   property p_hold;
      !o_sample_valid |-> $stable(o_cur_sample) && $stable(o_volt_sample);
   endproperty
   a_hold: assert property (p_hold) else $error("word moved");
   property p_bhold;
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
endmodule
bind wszc_waveform_zero_cross wszc_checker wszc_checker_inst
(
   .i_clk(i_clk), .i_resetn(i_resetn), .i_battery_mode(i_battery_mode),
   .i_sleep_mode(i_sleep_mode), .i_bready(i_bready), .o_bvalid(o_bvalid),
   .o_bresp(o_bresp), .o_current_amp_gain(o_current_amp_gain),
   .o_volt_amp_gain(o_volt_amp_gain), .o_mod_sample_en(o_mod_sample_en),
   .o_adc_powerdown(o_adc_powerdown), .o_cur_sample(o_cur_sample),
   .o_volt_sample(o_volt_sample), .o_sample_valid(o_sample_valid)
);

//--- wszc_mod_model.sv
`timescale 1ns/1ns
module wszc_mod_model
(
   input  wire       i_clk,      // clock
   input  wire       i_en,       // modulator enable
   input  wire [5:0] i_cur_n,    // cur ones per 32
   input  wire [5:0] i_volt_n,   // volt ones per 32
   output reg        o_cur_bit,  // cur stream
   output reg        o_volt_bit  // volt stream
);
   reg [4:0] k; // phase in period
   initial
   begin
      k = 5'h00;
      o_cur_bit = 1'b0;
      o_volt_bit = 1'b0;
   end
   // period 32, so any 32 bits in a row hold exactly n ones
   always @(posedge i_clk)
   begin
      if (i_en)
      begin
         k <= k + 5'h01;
         o_cur_bit <= {1'b0, k} < i_cur_n;
         o_volt_bit <= {1'b0, k} < i_volt_n;
      end
   end
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
`include "wszc_consts.vh"
module tb_top;
   localparam [11:0] A_GAIN = {`WSZC_IDX_GAIN, 2'b00};
   localparam [11:0] A_MODE = {`WSZC_IDX_WAVEFORM_MODE_REG, 2'b00};
   localparam [11:0] A_EN = {`WSZC_IDX_IRQ_EN3, 2'b00};
   localparam [11:0] A_ST = {`WSZC_IDX_IRQ_ST3, 2'b00};
   reg i_clk, i_resetn, i_battery_mode, i_sleep_mode, i_awvalid, i_wvalid;
   reg i_bready, i_arvalid, i_rready;
   reg [11:0] i_awaddr, i_araddr;
   reg [31:0] i_wdata, d;
   reg [5:0] cur_n, volt_n;
   wire i_cur_bit, i_volt_bit, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   wire o_mod_sample_en, o_adc_powerdown, o_sample_valid, o_irq;
   wire [1:0] o_bresp, o_rresp;
   wire [31:0] o_rdata;
   wire [2:0] o_current_amp_gain, o_volt_amp_gain;
   wire [23:0] o_cur_sample, o_volt_sample;
   integer err_count, checks_done, seed, i, t, t1, cyc;
   wszc_waveform_zero_cross wszc_waveform_zero_cross_inst
   (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_cur_bit(i_cur_bit), .i_volt_bit(i_volt_bit),
      .i_battery_mode(i_battery_mode), .i_sleep_mode(i_sleep_mode), .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(4'hF),
      .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
      .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
      .i_rready(i_rready), .o_current_amp_gain(o_current_amp_gain),
      .o_volt_amp_gain(o_volt_amp_gain), .o_mod_sample_en(o_mod_sample_en),
      .o_adc_powerdown(o_adc_powerdown), .o_cur_sample(o_cur_sample),
      .o_volt_sample(o_volt_sample), .o_sample_valid(o_sample_valid), .o_irq(o_irq)
   );
   wszc_mod_model wszc_mod_model_inst
   (
      .i_clk(i_clk), .i_en(o_mod_sample_en), .i_cur_n(cur_n), .i_volt_n(volt_n),
      .o_cur_bit(i_cur_bit), .o_volt_bit(i_volt_bit)
   );
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) cyc <= cyc + 1;
   function [23:0] ex(input [5:0] n);
   begin
      ex = {n, 18'h0} - 24'h400000; // (2n-32) * 2^17
   end
   endfunction
   task chk(input string nm, input [31:0] e, input [31:0] s);
   begin
      checks_done = checks_done + 1;
      if (s !== e)
      begin
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
         err_count = err_count + 1;
      end
   end
   endtask
   // response ready comes after a random stall to exercise waiting
   task wr(input [11:0] a, input [31:0] v, input [1:0] er);
      integer k, st;
   begin
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= v;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      st = {$random(seed)} % 4;
      k = 0;
      while (!(o_bvalid && i_bready) && k < 60)
      begin
         if (k >= st) i_bready <= 1'b1;
         @(posedge i_clk);
         k = k + 1;
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end
      i_bready <= 1'b0;
      chk("bvalid", 1, o_bvalid);
      chk("bresp", er, o_bresp);
   end
   endtask
   task rc(input string nm, input [11:0] a, input [1:0] er, input [31:0] m, input [31:0] e);
      integer k, st;
   begin
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      st = {$random(seed)} % 4;
      k = 0;
      while (!(o_rvalid && i_rready) && k < 60)
      begin
         if (k >= st) i_rready <= 1'b1;
         @(posedge i_clk);
         k = k + 1;
         if (o_arready) i_arvalid <= 1'b0;
      end
      i_rready <= 1'b0;
      d = o_rdata;
      chk("rvalid", 1, o_rvalid);
      chk("rresp", er, o_rresp);
      chk(nm, e, d & m);
   end
   endtask
   task sv_wait;
      integer k;
   begin
      k = 0;
      do
      begin
         @(posedge i_clk);
         k = k + 1;
      end while (!o_sample_valid && k < 400);
      chk("strobe", 1, o_sample_valid);
   end
   endtask
   // clear both flags, skip the line's lag, then wait for it to rise again
   task clr_wait(input integer lim);
   begin
      wr(A_ST, 32'h21, `WSZC_RESP_OKAY);
      repeat (2) @(posedge i_clk);
      t = 2;
      while (!o_irq && t < lim)
      begin
         @(posedge i_clk);
         t = t + 1;
      end
      chk("irq seen", 1, o_irq);
   end
   endtask
   task end_sim;
   begin
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   initial
   begin
      repeat (60000) @(posedge i_clk);
      err_count = err_count + 1;
      end_sim;
   end
   initial
   begin
      seed = 32'hC555BFAB;
      {err_count, checks_done, cyc} = 96'h0;
      {i_resetn, i_battery_mode, i_sleep_mode, i_awvalid, i_wvalid} = 5'h00;
      {i_bready, i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata} = 59'h0;
      cur_n = 6'd16;
      volt_n = 6'd24;
      repeat (5) @(posedge i_clk);
      i_resetn <= 1'b1;
      rc("gain rst", A_GAIN, `WSZC_RESP_OKAY, 32'hFFFFFFFF, 32'h0);
      rc("en rst", A_EN, `WSZC_RESP_OKAY, 32'hFFFFFFFF, 32'h0);
      rc("unmapped", 12'h3F0, `WSZC_RESP_SLVERR, 32'hFFFFFFFF, 32'h0);
      wr(12'h3F0, 32'hFF, `WSZC_RESP_SLVERR);
      for (i = 0; i < 5; i = i + 1)
      begin
         wr(A_GAIN, i * 32 + 4 - i, `WSZC_RESP_OKAY);
         rc("gain rd", A_GAIN, `WSZC_RESP_OKAY, 32'hFF, i * 32 + 4 - i);
         chk("cur gain", 4 - i, o_current_amp_gain);
         chk("volt gain", i, o_volt_amp_gain);
      end
      wr(A_GAIN, 32'hE6, `WSZC_RESP_OKAY);
      rc("gain kept", A_GAIN, `WSZC_RESP_OKAY, 32'hFF, 32'h80);
      // current at both saturation ends, voltage at the top one, then random densities
      for (i = 0; i < 6; i = i + 1)
      begin
         cur_n <= (i == 0) ? 6'd0 : (i == 1) ? 6'd32 : {$random(seed)} % 33;
         volt_n <= (i == 1) ? 6'd32 : 6'd17 + {$random(seed)} % 15;
         repeat (3) sv_wait;
         chk("cur word", ex(cur_n), o_cur_sample);
         chk("volt word", ex(volt_n), o_volt_sample);
         rc("wave one", A_ST + 12'h010, 2'b00, 32'hFFFFFFFF, ex(cur_n));
         rc("wave two", A_ST + 12'h01C, 2'b00, 32'hFFFFFFFF, ex(volt_n) >> 8);
      end
      wr(A_EN, 32'h20, `WSZC_RESP_OKAY);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(A_MODE, i, `WSZC_RESP_OKAY);
         // an event inside the first clear leaves the phase unknown
         repeat (2) clr_wait(3000);
         t1 = cyc;
         if (i == 3)
         begin
            repeat (20) @(posedge i_clk);
            chk("irq held", 1, o_irq);
         end
         clr_wait(3000);
         chk("rate", 160 << i, cyc - t1);
      end
      wr(A_EN, 32'h00, `WSZC_RESP_OKAY);
      repeat (400) @(posedge i_clk);
      chk("masked", 0, o_irq);
      rc("status", A_ST, `WSZC_RESP_OKAY, 32'h21, 32'h20);
      // filtered detection lags by many samples, raw detection does not
      wr(A_MODE, 0, `WSZC_RESP_OKAY);
      wr(A_EN, 32'h01, `WSZC_RESP_OKAY);
      volt_n <= 6'd24;
      repeat (1600) @(posedge i_clk);
      volt_n <= 6'd8;
      clr_wait(20000);
      chk("zx late", 1, t > 480);
      chk("zx irq", 1, o_irq);
      wr(A_MODE, 4, `WSZC_RESP_OKAY);
      repeat (2) sv_wait;
      volt_n <= 6'd24;
      clr_wait(800);
      chk("zx raw", 1, o_irq);
      rc("zx flag", A_ST, `WSZC_RESP_OKAY, 32'h01, 32'h01);
      for (i = 0; i < 2; i = i + 1)
      begin
         i_battery_mode <= (i == 0);
         i_sleep_mode <= (i == 1);
         repeat (10) @(posedge i_clk);
         chk("pd", 1, o_adc_powerdown);
         t = 0;
         repeat (400)
         begin
            @(posedge i_clk);
            if (o_sample_valid) t = t + 1;
         end
         chk("no samples", 0, t);
      end
      i_sleep_mode <= 1'b0;
      sv_wait;
      end_sim;
   end
endmodule
